// ### core/tirr_pkg.sv
// Package with the register map, field layout and reset values of the resistor register bank.
package tirr_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] TABLE_SELECT_OFS    = 8'h7F;
	localparam logic [7:0] MODE_OFS            = 8'h80;
	localparam logic [7:0] TEMP_INDEX_OFS      = 8'h81;
	localparam logic [7:0] RES_ZERO_OFS        = 8'h82;
	localparam logic [7:0] RES_ONE_OFS         = 8'h83;
	localparam logic [7:0] INT_MASK_OFS        = 8'h88;
	localparam logic [7:0] DEV_CONFIG_OFS      = 8'h89;
	localparam logic [7:0] LUT_FIRST_OFS       = 8'h80;
	localparam logic [7:0] LUT_LAST_OFS        = 8'hC7;

	// ------------------------------------------------------------
	// Tables and lookup depth
	// ------------------------------------------------------------
	localparam logic [1:0] TABLE_REGS          = 2'h1;
	localparam logic [1:0] TABLE_LUT_ZERO      = 2'h2;
	localparam logic [1:0] TABLE_LUT_ONE       = 2'h3;
	localparam int         LUT_DEPTH           = 72;
	localparam logic [6:0] LUT_LAST_INDEX      = 7'h47;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int         MODE_AUTO_INDEX_BIT = 0;
	localparam int         MODE_AUTO_TRACK_BIT = 1;
	localparam int         CFG_BUF_ONE_INV_BIT = 1;
	localparam int         MASK_FIELD_LSB      = 3;
	localparam int         MASK_FIELD_MSB      = 7;
	localparam logic [7:0] MASK_USED_BITS      = 8'hF8;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] TABLE_SELECT_RST    = 8'h00;
	localparam logic [7:0] MODE_RST            = 8'h03;
	localparam logic [7:0] TEMP_INDEX_RST      = 8'h00;
	localparam logic [7:0] RES_POSITION_RST    = 8'hFF;
	localparam logic [7:0] INT_MASK_RST        = 8'hF8;
	localparam logic [7:0] DEV_CONFIG_RST      = 8'h00;

endpackage

// ### core/tirr_regs.sv
// Register bank of the temperature indexed dual resistor: index, positions, lookup tables and masked interrupt.
//
// Function
// RULE1: A host-read-only index byte holds the value computed from the measured temperature and picks the lookup entry; host-writable here with auto indexing off.
// RULE2: The index addresses entries of two lookup tables that occupy bytes 80h to C7h of tables 02 and 03.
// RULE3: The resistor zero position is a read/write byte taking any value 00h to FFh and resetting to FFh.
// RULE4: The resistor one position is a read/write byte taking any value 00h to FFh and resetting to FFh.
// RULE5: The masked interrupt flag sets, driving buffer output one, only for events of channels whose mask bit is 1.
// RULE6: Mask bits 7 to 3 enable temperature, supply, monitor one, two and three; bits 2 to 0 are unused; enables reset to 1.
// RULE7: With all mask bits zero, no monitored channel ever sets the masked interrupt flag.
// RULE8: With automatic tracking off, a written resistor position is applied directly.
// RULE9: With automatic indexing off, the host writes the temperature index instead of the device computing it.
// RULE10: A two-bit field at 7Fh selects which of tables 00 to 03 appears in upper memory.
// RULE11: Buffer output one is the masked flag ORed with the invert bit XOR buffer input one.
// RULE12: With automatic tracking on, both positions reload from the lookup entries whenever the index changes.
`timescale 1ns/100ps
module tirr_regs (
	// Clock and reset
	input  wire logic       CLK_SYS,
	input  wire logic       RESET_N,
	// Byte access from the 2-wire serial engine
	input  wire logic [7:0] REG_ADDR,
	input  wire logic       REG_WR,
	input  wire logic [7:0] REG_WDATA,
	output logic      [7:0] REG_RDATA,
	// Temperature index from the conversion logic
	input  wire logic [7:0] TEMP_INDEX_IN,
	// Alarm or warning events per monitored channel
	input  wire logic       TEMP_EVENT,
	input  wire logic       VCC_EVENT,
	input  wire logic       ANALOG_MONITOR_ONE_EVENT,
	input  wire logic       ANALOG_MONITOR_TWO_EVENT,
	input  wire logic       ANALOG_MONITOR_THREE_EVENT,
	// Buffer one, open drain
	input  wire logic       BUFFER_ONE_INPUT,
	output logic            BUFFER_ONE_OUTPUT_O,
	output logic            BUFFER_ONE_OUTPUT_OE_N,
	// Resistor wiper positions and masked interrupt flag
	output logic      [7:0] RES_ZERO_POSITION,
	output logic      [7:0] RES_ONE_POSITION,
	output logic            MASKED_INTERRUPT_FLAG
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [7:0] table_select_q, table_select_d;
	logic [7:0] mode_q, mode_d;
	logic [7:0] temp_index_q, temp_index_d;
	logic [7:0] last_index_q, last_index_d;
	logic [7:0] res_zero_q, res_zero_d;
	logic [7:0] res_one_q, res_one_d;
	logic [7:0] int_mask_q, int_mask_d;
	logic [7:0] dev_config_q, dev_config_d;
	logic       masked_interrupt_flag_q, masked_interrupt_flag_d;
	logic       buffer_one_output_q, buffer_one_output_d;
	logic [7:0] rdata_q, rdata_d;

	localparam int LUT_DEPTH_L = tirr_pkg::LUT_DEPTH;

	logic [7:0] lut_zero [LUT_DEPTH_L];
	logic [7:0] lut_one  [LUT_DEPTH_L];

	logic [1:0] table_sel;
	logic       in_lut_range;
	logic       wr_regs;
	logic       auto_index_control;
	logic       auto_tracking_control;
	logic       buffer_one_invert;
	logic [6:0] lut_index;
	logic [4:0] channel_events;
	logic       index_changed;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	assign table_sel             = table_select_q[1:0]; // RULE10
	assign in_lut_range          = (REG_ADDR >= tirr_pkg::LUT_FIRST_OFS) && (REG_ADDR <= tirr_pkg::LUT_LAST_OFS);
	assign wr_regs               = REG_WR && (table_sel == tirr_pkg::TABLE_REGS);
	assign auto_index_control    = mode_q[tirr_pkg::MODE_AUTO_INDEX_BIT];
	assign auto_tracking_control = mode_q[tirr_pkg::MODE_AUTO_TRACK_BIT];
	assign buffer_one_invert     = dev_config_q[tirr_pkg::CFG_BUF_ONE_INV_BIT];
	assign channel_events        = {TEMP_EVENT, VCC_EVENT, ANALOG_MONITOR_ONE_EVENT,
	                                ANALOG_MONITOR_TWO_EVENT, ANALOG_MONITOR_THREE_EVENT};
	assign index_changed         = temp_index_q != last_index_q;

	// An index past the table end would read beyond the array, so it is held at the last entry.
	assign lut_index = (temp_index_q[6:0] > tirr_pkg::LUT_LAST_INDEX || temp_index_q[7]) ?
	                   tirr_pkg::LUT_LAST_INDEX : temp_index_q[6:0]; // RULE2

	// ------------------------------------------------------------
	// Lookup tables
	// ------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (REG_WR && in_lut_range && table_sel == tirr_pkg::TABLE_LUT_ZERO) begin
			lut_zero[REG_ADDR[6:0]] <= REG_WDATA; // RULE2
		end
		if (REG_WR && in_lut_range && table_sel == tirr_pkg::TABLE_LUT_ONE) begin
			lut_one[REG_ADDR[6:0]] <= REG_WDATA; // RULE2
		end
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		table_select_d = table_select_q;
		mode_d         = mode_q;
		int_mask_d     = int_mask_q;
		dev_config_d   = dev_config_q;
		last_index_d   = temp_index_q;
		temp_index_d   = temp_index_q;
		res_zero_d     = res_zero_q;
		res_one_d      = res_one_q;
		if (auto_index_control) begin
			temp_index_d = TEMP_INDEX_IN; // RULE1
		end
		// A host write wins over a tracking reload in the same cycle.
		if (auto_tracking_control && index_changed) begin
			res_zero_d = lut_zero[lut_index]; // RULE12
			res_one_d  = lut_one[lut_index]; // RULE12
		end
		if (REG_WR && REG_ADDR == tirr_pkg::TABLE_SELECT_OFS) begin
			table_select_d = REG_WDATA & 8'h03; // RULE10
		end
		if (wr_regs) begin
			case (REG_ADDR)
				tirr_pkg::MODE_OFS: begin
					mode_d = REG_WDATA & 8'h03;
				end
				tirr_pkg::TEMP_INDEX_OFS: begin
					if (!auto_index_control) begin
						temp_index_d = REG_WDATA; // RULE9
					end
				end
				tirr_pkg::RES_ZERO_OFS: begin
					res_zero_d = REG_WDATA; // RULE3 RULE8
				end
				tirr_pkg::RES_ONE_OFS: begin
					res_one_d = REG_WDATA; // RULE4 RULE8
				end
				tirr_pkg::INT_MASK_OFS: begin
					int_mask_d = REG_WDATA & tirr_pkg::MASK_USED_BITS; // RULE6
				end
				tirr_pkg::DEV_CONFIG_OFS: begin
					dev_config_d = REG_WDATA;
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		masked_interrupt_flag_d = |(channel_events &
		                            int_mask_q[tirr_pkg::MASK_FIELD_MSB:tirr_pkg::MASK_FIELD_LSB]); // RULE5 RULE7
		buffer_one_output_d     = masked_interrupt_flag_q | (buffer_one_invert ^ BUFFER_ONE_INPUT); // RULE11
		rdata_d                 = 8'h00;
		if (REG_ADDR == tirr_pkg::TABLE_SELECT_OFS) begin
			rdata_d = table_select_q;
		end else if (REG_ADDR >= tirr_pkg::LUT_FIRST_OFS) begin
			case (table_sel)
				tirr_pkg::TABLE_REGS: begin
					case (REG_ADDR)
						tirr_pkg::MODE_OFS:       rdata_d = mode_q;
						tirr_pkg::TEMP_INDEX_OFS: rdata_d = temp_index_q;
						tirr_pkg::RES_ZERO_OFS:   rdata_d = res_zero_q;
						tirr_pkg::RES_ONE_OFS:    rdata_d = res_one_q;
						tirr_pkg::INT_MASK_OFS:   rdata_d = int_mask_q;
						tirr_pkg::DEV_CONFIG_OFS: rdata_d = dev_config_q;
						default:                  rdata_d = 8'h00;
					endcase
				end
				tirr_pkg::TABLE_LUT_ZERO: rdata_d = in_lut_range ? lut_zero[REG_ADDR[6:0]] : 8'h00;
				tirr_pkg::TABLE_LUT_ONE:  rdata_d = in_lut_range ? lut_one[REG_ADDR[6:0]] : 8'h00;
				default:                  rdata_d = 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			table_select_q          <= tirr_pkg::TABLE_SELECT_RST;
			mode_q                  <= tirr_pkg::MODE_RST;
			temp_index_q            <= tirr_pkg::TEMP_INDEX_RST;
			last_index_q            <= tirr_pkg::TEMP_INDEX_RST;
			res_zero_q              <= tirr_pkg::RES_POSITION_RST; // RULE3
			res_one_q               <= tirr_pkg::RES_POSITION_RST; // RULE4
			int_mask_q              <= tirr_pkg::INT_MASK_RST; // RULE6
			dev_config_q            <= tirr_pkg::DEV_CONFIG_RST;
			masked_interrupt_flag_q <= 1'b0;
			buffer_one_output_q     <= 1'b1;
			rdata_q                 <= 8'h00;
		end else begin
			table_select_q          <= table_select_d;
			mode_q                  <= mode_d;
			temp_index_q            <= temp_index_d;
			last_index_q            <= last_index_d;
			res_zero_q              <= res_zero_d;
			res_one_q               <= res_one_d;
			int_mask_q              <= int_mask_d;
			dev_config_q            <= dev_config_d;
			masked_interrupt_flag_q <= masked_interrupt_flag_d;
			buffer_one_output_q     <= buffer_one_output_d;
			rdata_q                 <= rdata_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// The pin only ever pulls low; a high level is left to the external pull-up.
	assign BUFFER_ONE_OUTPUT_O    = 1'b0;
	assign BUFFER_ONE_OUTPUT_OE_N = buffer_one_output_q; // RULE11
	assign REG_RDATA              = rdata_q;
	assign RES_ZERO_POSITION      = res_zero_q;
	assign RES_ONE_POSITION       = res_one_q;
	assign MASKED_INTERRUPT_FLAG  = masked_interrupt_flag_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);

	sequence s_index_moves;
		auto_tracking_control && (temp_index_q != last_index_q) && !wr_regs;
	endsequence

	property p_index_follows;
		auto_index_control && !wr_regs |=> temp_index_q == $past(TEMP_INDEX_IN);
	endproperty
	a_index_follows: assert property (p_index_follows) else $error("index did not follow sensor"); // RULE1

	property p_res_zero_write;
		wr_regs && REG_ADDR == tirr_pkg::RES_ZERO_OFS |=> res_zero_q == $past(REG_WDATA);
	endproperty
	a_res_zero_write: assert property (p_res_zero_write) else $error("resistor zero write lost"); // RULE3

	property p_res_one_write;
		wr_regs && REG_ADDR == tirr_pkg::RES_ONE_OFS |=> RES_ONE_POSITION == $past(REG_WDATA);
	endproperty
	a_res_one_write: assert property (p_res_one_write) else $error("resistor one write lost"); // RULE4

	property p_flag_cause;
		$rose(MASKED_INTERRUPT_FLAG) |-> $past(|(channel_events & int_mask_q[7:3]));
	endproperty
	a_flag_cause: assert property (p_flag_cause) else $error("flag set without enabled event"); // RULE5

	property p_mask_zero_quiet;
		int_mask_q == 8'h00 ##1 int_mask_q == 8'h00 |-> !MASKED_INTERRUPT_FLAG;
	endproperty
	a_mask_zero_quiet: assert property (p_mask_zero_quiet) else $error("flag set with empty mask"); // RULE7

	property p_mask_unused;
		int_mask_q[2:0] == 3'h0;
	endproperty
	a_mask_unused: assert property (p_mask_unused) else $error("unused mask bits set"); // RULE6

	property p_manual_index;
		!auto_index_control && wr_regs && REG_ADDR == tirr_pkg::TEMP_INDEX_OFS |=> temp_index_q == $past(REG_WDATA);
	endproperty
	a_manual_index: assert property (p_manual_index) else $error("manual index write lost"); // RULE9

	property p_manual_hold;
		!auto_tracking_control && !wr_regs |=> res_zero_q == $past(res_zero_q);
	endproperty
	a_manual_hold: assert property (p_manual_hold) else $error("manual position changed"); // RULE8

	property p_tracking_reload;
		s_index_moves |=> res_zero_q == $past(lut_zero[lut_index]) && res_one_q == $past(lut_one[lut_index]);
	endproperty
	a_tracking_reload: assert property (p_tracking_reload) else $error("tracking reload missed"); // RULE12

	property p_buffer_one;
		##1 1'b1 |-> BUFFER_ONE_OUTPUT_OE_N == $past(masked_interrupt_flag_q | (buffer_one_invert ^ BUFFER_ONE_INPUT));
	endproperty
	a_buffer_one: assert property (p_buffer_one) else $error("buffer one output wrong"); // RULE11

	property p_table_select;
		REG_WR && REG_ADDR == tirr_pkg::TABLE_SELECT_OFS |=> table_sel == $past(REG_WDATA[1:0]);
	endproperty
	a_table_select: assert property (p_table_select) else $error("table select not taken"); // RULE10

endmodule

// ### testbench/tirr_host_model.sv
// Host model that issues byte writes and reads toward the resistor register bank.
`timescale 1ns/100ps
module tirr_host_model (
	// Clock
	input  wire logic       CLK_SYS,
	// Byte access toward the bank
	output logic      [7:0] REG_ADDR,
	output logic            REG_WR,
	output logic      [7:0] REG_WDATA,
	input  wire logic [7:0] REG_RDATA
);
	initial begin
		REG_ADDR  = 8'h00;
		REG_WR    = 1'b0;
		REG_WDATA = 8'h00;
	end

	// The data lines are inverted after a write so a stale byte is never mistaken for a held one.
	task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK_SYS);
		#1;
		REG_ADDR  = a;
		REG_WR    = 1'b1;
		REG_WDATA = d;
		@(posedge CLK_SYS);
		#1;
		REG_WR    = 1'b0;
		REG_WDATA = ~d;
	endtask

	task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
		@(posedge CLK_SYS);
		#1;
		REG_ADDR = a;
		@(posedge CLK_SYS);
		#1;
		d = REG_RDATA;
	endtask
endmodule

// ### testbench/tirr_regs_tb_top.sv
// Testbench for the resistor register bank.
`timescale 1ns/100ps
module tirr_regs_tb_top;
	logic       clk_sys;
	logic       reset_n;
	logic [7:0] reg_addr;
	logic       reg_wr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic [7:0] temp_index_in;
	logic [4:0] events;
	logic       buffer_one_input;
	logic [7:0] res_zero;
	logic [7:0] res_one;
	logic       flag;
	logic       buf_oe_n;
	logic       buf_o;
	int         n_fail;
	int         total_checks;

	tirr_host_model i_tirr_host_model (
		.CLK_SYS   (clk_sys),
		.REG_ADDR  (reg_addr),
		.REG_WR    (reg_wr),
		.REG_WDATA (reg_wdata),
		.REG_RDATA (reg_rdata)
	);

	tirr_regs i_tirr_regs (
		.CLK_SYS                    (clk_sys),
		.RESET_N                    (reset_n),
		.REG_ADDR                   (reg_addr),
		.REG_WR                     (reg_wr),
		.REG_WDATA                  (reg_wdata),
		.REG_RDATA                  (reg_rdata),
		.TEMP_INDEX_IN              (temp_index_in),
		.TEMP_EVENT                 (events[4]),
		.VCC_EVENT                  (events[3]),
		.ANALOG_MONITOR_ONE_EVENT   (events[2]),
		.ANALOG_MONITOR_TWO_EVENT   (events[1]),
		.ANALOG_MONITOR_THREE_EVENT (events[0]),
		.BUFFER_ONE_INPUT           (buffer_one_input),
		.BUFFER_ONE_OUTPUT_O        (buf_o),
		.BUFFER_ONE_OUTPUT_OE_N     (buf_oe_n),
		.RES_ZERO_POSITION          (res_zero),
		.RES_ONE_POSITION           (res_one),
		.MASKED_INTERRUPT_FLAG      (flag)
	);

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_tirr_host_model.wr_byte(a, d);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string name);
		logic [7:0] d;
		i_tirr_host_model.rd_byte(a, d);
		chk(name, d, exp);
	endtask

	task automatic give_verdict();
		if (n_fail == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// The whole sequence needs well under a thousand cycles.
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		give_verdict();
	end

	initial begin
		n_fail = 0;
		total_checks = 0;
		reset_n = 1'b0;
		temp_index_in = 8'h00;
		events = 5'h00;
		buffer_one_input = 1'b1;
		repeat (6) @(posedge clk_sys);
		#1;
		reset_n = 1'b1;
		chk("res_zero_rst", res_zero, 8'hFF);
		chk("res_one_rst", res_one, 8'hFF);
		rdchk(tirr_pkg::RES_ZERO_OFS, 8'h00, "table00");
		wr(tirr_pkg::TABLE_SELECT_OFS, 8'hFD);
		rdchk(tirr_pkg::TABLE_SELECT_OFS, 8'h01, "tsel");
		rdchk(tirr_pkg::RES_ZERO_OFS, 8'hFF, "rz_rst");
		rdchk(tirr_pkg::RES_ONE_OFS, 8'hFF, "ro_rst");
		rdchk(tirr_pkg::INT_MASK_OFS, 8'hF8, "mask_rst");
		rdchk(8'h84, 8'h00, "reserved");
		wr(tirr_pkg::MODE_OFS, 8'h01);
		wr(tirr_pkg::RES_ZERO_OFS, 8'h00);
		wr(tirr_pkg::RES_ONE_OFS, 8'hA5);
		@(posedge clk_sys);
		#1;
		chk("res_zero", res_zero, 8'h00);
		chk("res_one", res_one, 8'hA5);
		rdchk(tirr_pkg::RES_ZERO_OFS, 8'h00, "rz");
		rdchk(tirr_pkg::RES_ONE_OFS, 8'hA5, "ro");
		temp_index_in = 8'h05;
		repeat (3) @(posedge clk_sys);
		rdchk(tirr_pkg::TEMP_INDEX_OFS, 8'h05, "index");
		wr(tirr_pkg::TEMP_INDEX_OFS, 8'h33);
		rdchk(tirr_pkg::TEMP_INDEX_OFS, 8'h05, "index_ro");
		wr(tirr_pkg::MODE_OFS, 8'h00);
		wr(tirr_pkg::TEMP_INDEX_OFS, 8'h33);
		rdchk(tirr_pkg::TEMP_INDEX_OFS, 8'h33, "index_man");
		// Each mask bit alone against each channel event alone.
		for (int i = 0; i < 5; i++) begin
			wr(tirr_pkg::INT_MASK_OFS, 8'h08 << i);
			for (int j = 0; j < 5; j++) begin
				events = 5'h01 << j;
				repeat (3) @(posedge clk_sys);
				#1;
				chk("flag", {7'h00, flag}, {7'h00, i == j});
			end
		end
		wr(tirr_pkg::INT_MASK_OFS, 8'hFF);
		rdchk(tirr_pkg::INT_MASK_OFS, 8'hF8, "mask_rb");
		wr(tirr_pkg::INT_MASK_OFS, 8'h00);
		events = 5'h1F;
		repeat (3) @(posedge clk_sys);
		chk("flag_off", {7'h00, flag}, 8'h00);
		for (int k = 0; k < 4; k++) begin
			wr(tirr_pkg::DEV_CONFIG_OFS, {6'h00, k[1], 1'b0});
			buffer_one_input = k[0];
			repeat (3) @(posedge clk_sys);
			#1;
			chk("buf", {7'h00, buf_oe_n}, {7'h00, k[1] ^ k[0]});
		end
		chk("buf_o", {7'h00, buf_o}, 8'h00);
		wr(tirr_pkg::INT_MASK_OFS, 8'hF8);
		repeat (4) @(posedge clk_sys);
		chk("buf_flag", {7'h00, buf_oe_n}, 8'h01);
		wr(tirr_pkg::TABLE_SELECT_OFS, 8'h02);
		wr(8'h85, 8'h3C);
		wr(tirr_pkg::LUT_LAST_OFS, 8'h11);
		rdchk(8'h85, 8'h3C, "lut0");
		wr(tirr_pkg::TABLE_SELECT_OFS, 8'h03);
		wr(8'h85, 8'hC3);
		wr(tirr_pkg::LUT_LAST_OFS, 8'h22);
		rdchk(tirr_pkg::LUT_LAST_OFS, 8'h22, "lut1");
		wr(tirr_pkg::TABLE_SELECT_OFS, 8'h01);
		wr(tirr_pkg::MODE_OFS, 8'h03);
		repeat (5) @(posedge clk_sys);
		#1;
		chk("track_zero", res_zero, 8'h3C);
		chk("track_one", res_one, 8'hC3);
		temp_index_in = 8'h60;
		repeat (5) @(posedge clk_sys);
		#1;
		chk("clamp_zero", res_zero, 8'h11);
		chk("clamp_one", res_one, 8'h22);
		give_verdict();
	end
endmodule
